// >>> core/ltr_thermal_replica.sv
`timescale 1ns/1ps
`include "ltr_map.svh"

// What this block does
// - True RMS per phase at 1 kHz
// - Largest phase RMS feeds the model
// - Level moves toward current ratio squared
// - Compare temperature to thresholds each step
// - Off mode silences flags; pulsed default
// - Pulsed mode pulses trip above threshold
// - Locked trip holds until below unlock
// - Alarm threshold 60..200, default 80
// - Trip threshold 60..200, default 100
// - Rated temperature 60..200, default 100
// - Base temperature 0..40, default 25
// - Unlock threshold 20..200, default 60
// - Fixed ambient 0..40, default 25
// - Startup level 0..60 percent, default 0
// - Rated load current 20..150, default 100
// - Time constant 1..999 minutes, default 10
// - Measured or fixed ambient by selector
// - Block input silences protection outputs
// - Heat reset reloads startup level
// - Alarm, trip, lock flags plus temperature
// - Operate time tracks theoretical curve closely
// - Temperature is overtemperature plus ambient
// - Startup relative to rated temperature rise
module ltr_thermal_replica #(
    parameter int unsigned STEP_CYCLES      = `LTR_CLK_HZ / `LTR_SAMPLE_HZ,
    parameter int unsigned TRIP_PULSE_STEPS = `LTR_TRIP_PULSE_STEPS
) (
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire logic signed [15:0] sample_l1,
    input  wire logic signed [15:0] sample_l2,
    input  wire logic signed [15:0] sample_l3,
    input  wire logic        [7:0]  measured_ambient,
    input  wire logic        [1:0]  operation_mode_select,
    input  wire logic        [7:0]  alarm_threshold,
    input  wire logic        [7:0]  trip_threshold,
    input  wire logic        [7:0]  rated_temperature,
    input  wire logic        [7:0]  base_temperature,
    input  wire logic        [7:0]  unlock_threshold,
    input  wire logic        [7:0]  fixed_ambient_temperature,
    input  wire logic        [7:0]  startup_level,
    input  wire logic        [7:0]  rated_load_current,
    input  wire logic        [9:0]  heating_time_constant,
    input  wire logic               ambient_sensor_select,
    input  wire logic               block_input,
    input  wire logic               heat_reset_input,
    output logic                    alarm_flag,
    output logic                    general_trip_flag,
    output logic                    reclose_lock_flag,
    output logic             [15:0] calculated_temperature_value,
    output logic             [15:0] phase1_rms_current,
    output logic             [15:0] phase2_rms_current,
    output logic             [15:0] phase3_rms_current
);

    function automatic logic [9:0] clamp_setting(
        input logic [9:0] v,
        input logic [9:0] lo,
        input logic [9:0] hi
    );
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction : clamp_setting

    logic [31:0]        step_cnt_r;
    logic               step_tick_r;
    logic               blk_meta_r;
    logic               blk_sync_r;
    logic               hrst_meta_r;
    logic               hrst_sync_r;
    ltr_pkg::ltr_mode_t cfg_mode_r;
    logic [7:0]         cfg_alarm_r;
    logic [7:0]         cfg_trip_r;
    logic [7:0]         cfg_rated_r;
    logic [7:0]         cfg_base_r;
    logic [7:0]         cfg_unl_r;
    logic [7:0]         cfg_amb_r;
    logic [7:0]         cfg_start_r;
    logic [7:0]         cfg_iload_r;
    logic [9:0]         cfg_tau_r;
    logic               cfg_sensor_r;
    logic [7:0]         amb_r;
    logic [2:0]         rms_done;
    logic [15:0]        max_rms;
    logic [31:0]        max_sq;
    logic [15:0]        i_rated;
    logic [31:0]        in_sq;
    logic [31:0]        tau_steps;
    ltr_pkg::ltr_state_t state_r;
    ltr_pkg::ltr_state_t state_nxt;
    logic               div_load;
    logic [47:0]        div_in;
    logic [31:0]        div_den_in;
    logic [31:0]        div_den_r;
    logic [31:0]        div_rem_r;
    logic [47:0]        div_quo_r;
    logic [5:0]         div_cnt_r;
    logic               div_busy_r;
    logic               div_done_r;
    logic [32:0]        div_trial;
    logic               div_fit;
    logic [47:0]        ratio_q16;
    logic [47:0]        target_q40;
    logic               cool_r;
    logic               cool_nxt;
    logic               init_pend_r;
    logic [47:0]        h_r;
    logic [47:0]        startup_q40;
    logic [63:0]        over_full;
    logic [31:0]        over_q16;
    logic [32:0]        temp_q16;
    logic               above_alarm;
    logic               above_trip;
    logic               below_unlock;
    logic               active;
    logic               latch_r;
    logic               armed_r;
    logic [15:0]        pulse_cnt_r;

    // Calculation tick at the sample rate
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            step_cnt_r  <= 32'h0;
            step_tick_r <= 1'b0;
        end else if (step_cnt_r == 32'(STEP_CYCLES - 1)) begin
            step_cnt_r  <= 32'h0;
            step_tick_r <= 1'b1;
        end else begin
            step_cnt_r  <= step_cnt_r + 32'h1;
            step_tick_r <= 1'b0;
        end
    end

    // Relay logic may run on another clock
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            blk_meta_r  <= 1'b0;
            blk_sync_r  <= 1'b0;
            hrst_meta_r <= 1'b0;
            hrst_sync_r <= 1'b0;
        end else begin
            blk_meta_r  <= block_input;
            blk_sync_r  <= blk_meta_r;
            hrst_meta_r <= heat_reset_input;
            hrst_sync_r <= hrst_meta_r;
        end
    end

    // pulsed after reset, spare code read as pulsed
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_mode_r <= ltr_pkg::LTR_MODE_PULSED;
        end else if (operation_mode_select == 2'h3) begin
            cfg_mode_r <= ltr_pkg::LTR_MODE_PULSED;
        end else begin
            cfg_mode_r <= ltr_pkg::ltr_mode_t'(operation_mode_select);
        end
    end

    // Out of range settings are pinned to the nearest limit
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_alarm_r  <= `LTR_ALM_DEF;
            cfg_trip_r   <= `LTR_TRIP_DEF;
            cfg_rated_r  <= `LTR_RATED_DEF;
            cfg_base_r   <= `LTR_BASE_DEF;
            cfg_unl_r    <= `LTR_UNL_DEF;
            cfg_amb_r    <= `LTR_AMB_DEF;
            cfg_start_r  <= `LTR_START_DEF;
            cfg_iload_r  <= `LTR_ILOAD_DEF;
            cfg_tau_r    <= `LTR_TAU_DEF;
            cfg_sensor_r <= `LTR_SENSOR_DEF;
        end else begin
            cfg_alarm_r  <= 8'(clamp_setting({2'h0, alarm_threshold},
                            {2'h0, `LTR_ALM_MIN}, {2'h0, `LTR_ALM_MAX}));
            cfg_trip_r   <= 8'(clamp_setting({2'h0, trip_threshold},
                            {2'h0, `LTR_TRIP_MIN}, {2'h0, `LTR_TRIP_MAX}));
            cfg_rated_r  <= 8'(clamp_setting({2'h0, rated_temperature},
                            {2'h0, `LTR_RATED_MIN}, {2'h0, `LTR_RATED_MAX}));
            cfg_base_r   <= 8'(clamp_setting({2'h0, base_temperature},
                            {2'h0, `LTR_BASE_MIN}, {2'h0, `LTR_BASE_MAX}));
            cfg_unl_r    <= 8'(clamp_setting({2'h0, unlock_threshold},
                            {2'h0, `LTR_UNL_MIN}, {2'h0, `LTR_UNL_MAX}));
            cfg_amb_r    <= 8'(clamp_setting(
                            {2'h0, fixed_ambient_temperature},
                            {2'h0, `LTR_AMB_MIN}, {2'h0, `LTR_AMB_MAX}));
            cfg_start_r  <= 8'(clamp_setting({2'h0, startup_level},
                            {2'h0, `LTR_START_MIN}, {2'h0, `LTR_START_MAX}));
            cfg_iload_r  <= 8'(clamp_setting({2'h0, rated_load_current},
                            {2'h0, `LTR_ILOAD_MIN}, {2'h0, `LTR_ILOAD_MAX}));
            cfg_tau_r    <= clamp_setting(heating_time_constant,
                            `LTR_TAU_MIN, `LTR_TAU_MAX);
            cfg_sensor_r <= ambient_sensor_select;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            amb_r <= `LTR_AMB_DEF;
        end else begin
            amb_r <= cfg_sensor_r ? measured_ambient : cfg_amb_r;
        end
    end

    ltr_rms_phase u_rms1 (
        .clk       (clk),
        .resetn    (resetn),
        .step_tick (step_tick_r),
        .sample    (sample_l1),
        .rms       (phase1_rms_current),
        .done      (rms_done[0])
    );

    ltr_rms_phase u_rms2 (
        .clk       (clk),
        .resetn    (resetn),
        .step_tick (step_tick_r),
        .sample    (sample_l2),
        .rms       (phase2_rms_current),
        .done      (rms_done[1])
    );

    ltr_rms_phase u_rms3 (
        .clk       (clk),
        .resetn    (resetn),
        .step_tick (step_tick_r),
        .sample    (sample_l3),
        .rms       (phase3_rms_current),
        .done      (rms_done[2])
    );

    always_comb begin
        max_rms = phase1_rms_current;
        if (phase2_rms_current > max_rms) begin
            max_rms = phase2_rms_current;
        end
        if (phase3_rms_current > max_rms) begin
            max_rms = phase3_rms_current;
        end
    end

    assign max_sq    = 32'(max_rms) * 32'(max_rms);
    assign i_rated   = 16'(cfg_iload_r * `LTR_CNT_PER_PCT);
    assign in_sq     = 32'(i_rated) * 32'(i_rated);
    assign tau_steps = 32'(cfg_tau_r)
                     * 32'(`LTR_SEC_PER_MIN * `LTR_SAMPLE_HZ);

    // Ratio is capped so the level stays inside 48 bits
    assign ratio_q16  = (div_quo_r > `LTR_RATIO_MAX) ? `LTR_RATIO_MAX
                                                    : div_quo_r;
    assign target_q40 = {ratio_q16[23:0], 24'h000000};

    // One shared restoring divider, 48 cycles per quotient
    assign div_trial = {div_rem_r, div_quo_r[47]};
    assign div_fit   = div_trial >= {1'b0, div_den_r};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_den_r  <= 32'h0;
            div_rem_r  <= 32'h0;
            div_quo_r  <= 48'h0;
            div_cnt_r  <= 6'h00;
            div_busy_r <= 1'b0;
            div_done_r <= 1'b0;
        end else begin
            div_done_r <= 1'b0;
            if (div_load) begin
                div_den_r  <= div_den_in;
                div_rem_r  <= 32'h0;
                div_quo_r  <= div_in;
                div_cnt_r  <= 6'h30;
                div_busy_r <= 1'b1;
            end else if (div_busy_r) begin
                div_rem_r  <= div_fit ? 32'(div_trial - {1'b0, div_den_r})
                                      : div_trial[31:0];
                div_quo_r  <= {div_quo_r[46:0], div_fit};
                div_cnt_r  <= div_cnt_r - 6'h01;
                if (div_cnt_r == 6'h01) begin
                    div_busy_r <= 1'b0;
                    div_done_r <= 1'b1;
                end
            end
        end
    end

    always_comb begin
        state_nxt  = state_r;
        div_load   = 1'b0;
        div_in     = 48'h0;
        div_den_in = 32'h0;
        cool_nxt   = cool_r;
        case (state_r)
            ltr_pkg::LTR_ST_IDLE: begin
                if (rms_done[0]) begin
                    div_load   = 1'b1;
                    div_in     = {max_sq, 16'h0000};
                    div_den_in = in_sq;
                    state_nxt  = ltr_pkg::LTR_ST_RATIO;
                end
            end
            ltr_pkg::LTR_ST_RATIO: begin
                if (div_done_r) begin
                    cool_nxt   = target_q40 < h_r;
                    div_load   = 1'b1;
                    div_in     = cool_nxt ? h_r - target_q40
                                          : target_q40 - h_r;
                    div_den_in = tau_steps;
                    state_nxt  = ltr_pkg::LTR_ST_INCR;
                end
            end
            ltr_pkg::LTR_ST_INCR: begin
                if (div_done_r) begin
                    state_nxt = ltr_pkg::LTR_ST_APPLY;
                end
            end
            ltr_pkg::LTR_ST_APPLY: begin
                state_nxt = ltr_pkg::LTR_ST_IDLE;
            end
            default: begin
                state_nxt = ltr_pkg::LTR_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ltr_pkg::LTR_ST_IDLE;
            cool_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cool_r  <= cool_nxt;
        end
    end

    // startup percent of rated rise, Q40
    assign startup_q40 = 48'(cfg_start_r * `LTR_PCT_TO_Q40);

    // reset default startup level loaded right after reset release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            init_pend_r <= 1'b1;
            h_r         <= 48'h0;
        end else begin
            init_pend_r <= 1'b0;
            if (init_pend_r || hrst_sync_r) begin
                h_r <= startup_q40;
            end else if (state_r == ltr_pkg::LTR_ST_APPLY) begin
                h_r <= cool_r ? h_r - div_quo_r : h_r + div_quo_r;
            end
        end
    end

    // full level used; a cut level reads a degree low
    assign over_full = 64'(h_r) * 64'(cfg_rated_r - cfg_base_r);
    assign over_q16  = over_full[55:24];
    assign temp_q16 = {1'b0, over_q16} + {9'h000, amb_r, 16'h0000};

    // threshold compares
    // Whole degrees, so flags agree with the shown temperature
    assign above_alarm  = temp_q16[32:16] > {9'h000, cfg_alarm_r};
    assign above_trip   = temp_q16[32:16] > {9'h000, cfg_trip_r};
    assign below_unlock = temp_q16 < {9'h000, cfg_unl_r, 16'h0000};
    // off mode and block silence the alarm, trip and lock flags
    assign active = (cfg_mode_r != ltr_pkg::LTR_MODE_OFF) && !blk_sync_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            latch_r <= 1'b0;
        end else if (!active) begin
            latch_r <= 1'b0;
        end else if (above_trip) begin
            latch_r <= 1'b1;
        end else if (below_unlock) begin
            latch_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            armed_r     <= 1'b1;
            pulse_cnt_r <= 16'h0000;
        end else if (!active) begin
            armed_r     <= 1'b1;
            pulse_cnt_r <= 16'h0000;
        // fixed width, rearm only after clearing
        end else if (above_trip && armed_r) begin
            armed_r     <= 1'b0;
            pulse_cnt_r <= 16'(TRIP_PULSE_STEPS);
        end else begin
            if (!above_trip) begin
                armed_r <= 1'b1;
            end
            if (step_tick_r && pulse_cnt_r != 16'h0000) begin
                pulse_cnt_r <= pulse_cnt_r - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alarm_flag        <= 1'b0;
            general_trip_flag <= 1'b0;
            reclose_lock_flag <= 1'b0;
        end else begin
            alarm_flag        <= active && above_alarm;
            general_trip_flag <= active &&
                ((cfg_mode_r == ltr_pkg::LTR_MODE_LOCKED) ? latch_r
                                               : pulse_cnt_r != 16'h0000);
            reclose_lock_flag <= active && latch_r;
        end
    end

    // held by Q40 level and exact per-step division
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            calculated_temperature_value <= 16'h0000;
        end else if (temp_q16[32]) begin
            calculated_temperature_value <= 16'hFFFF;
        end else begin
            calculated_temperature_value <= temp_q16[31:16];
        end
    end

endmodule : ltr_thermal_replica

// >>> core/ltr_map.svh
`ifndef LTR_MAP_SVH
`define LTR_MAP_SVH

// Setting ranges and reset defaults, whole degrees unless noted
`define LTR_ALM_MIN        8'h3C
`define LTR_ALM_MAX        8'hC8
`define LTR_ALM_DEF        8'h50
`define LTR_TRIP_MIN       8'h3C
`define LTR_TRIP_MAX       8'hC8
`define LTR_TRIP_DEF       8'h64
`define LTR_RATED_MIN      8'h3C
`define LTR_RATED_MAX      8'hC8
`define LTR_RATED_DEF      8'h64
`define LTR_BASE_MIN       8'h00
`define LTR_BASE_MAX       8'h28
`define LTR_BASE_DEF       8'h19
`define LTR_UNL_MIN        8'h14
`define LTR_UNL_MAX        8'hC8
`define LTR_UNL_DEF        8'h3C
`define LTR_AMB_MIN        8'h00
`define LTR_AMB_MAX        8'h28
`define LTR_AMB_DEF        8'h19
// Percent
`define LTR_START_MIN      8'h00
`define LTR_START_MAX      8'h3C
`define LTR_START_DEF      8'h00
`define LTR_ILOAD_MIN      8'h14
`define LTR_ILOAD_MAX      8'h96
`define LTR_ILOAD_DEF      8'h64
// Minutes
`define LTR_TAU_MIN        10'h001
`define LTR_TAU_MAX        10'h3E7
`define LTR_TAU_DEF        10'h00A
`define LTR_SENSOR_DEF     1'h0

// Timing
`define LTR_CLK_HZ         50000000
`define LTR_SAMPLE_HZ      1000
`define LTR_SEC_PER_MIN    60
`define LTR_TRIP_PULSE_STEPS 100
// Samples per RMS window, one 50 Hz period
`define LTR_RMS_WIN        20

// Scaling: sample counts per percent of rated current
`define LTR_CNT_PER_PCT    16'h000A
// Thermal level is Q40; this is one percent of unity
`define LTR_PCT_TO_Q40     48'h0028F5C28F6
// Largest current ratio squared, Q16
`define LTR_RATIO_MAX      48'h0000007F0000

`endif

// >>> core/ltr_pkg.sv
package ltr_pkg;

    typedef enum logic [1:0] {
        LTR_MODE_OFF    = 2'h0,
        LTR_MODE_PULSED = 2'h1,
        LTR_MODE_LOCKED = 2'h2
    } ltr_mode_t;

    typedef enum logic [1:0] {
        LTR_ST_IDLE  = 2'h0,
        LTR_ST_RATIO = 2'h1,
        LTR_ST_INCR  = 2'h3,
        LTR_ST_APPLY = 2'h2
    } ltr_state_t;

endpackage : ltr_pkg

// >>> core/ltr_rms_phase.sv
`timescale 1ns/1ps
`include "ltr_map.svh"

module ltr_rms_phase (
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire logic               step_tick,
    input  wire logic signed [15:0] sample,
    output logic             [15:0] rms,
    output logic                    done
);

    logic signed [15:0] win_r [0:`LTR_RMS_WIN-1];
    logic        [4:0]  idx_r;
    logic        [35:0] sum_r;
    logic               start_r;
    logic               busy_r;
    logic        [3:0]  bit_r;
    logic        [15:0] root_r;
    logic        [31:0] sq_new;
    logic        [31:0] sq_old;
    logic        [15:0] trial;
    logic        [36:0] trial_sq20;
    logic               fits;

    assign sq_new     = $unsigned(32'(sample) * 32'(sample));
    assign sq_old     = $unsigned(32'(win_r[idx_r]) * 32'(win_r[idx_r]));
    assign trial      = root_r | (16'h0001 << bit_r);
    assign trial_sq20 = 37'(trial) * 37'(trial) * 37'(`LTR_RMS_WIN);
    assign fits       = trial_sq20 <= {1'b0, sum_r};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < `LTR_RMS_WIN; i++) begin
                win_r[i] <= 16'sh0000;
            end
            idx_r <= 5'h00;
            sum_r <= 36'h0;
        end else if (step_tick) begin
            win_r[idx_r] <= sample;
            sum_r        <= sum_r + 36'(sq_new) - 36'(sq_old);
            if (idx_r == 5'(`LTR_RMS_WIN - 1)) begin
                idx_r <= 5'h00;
            end else begin
                idx_r <= idx_r + 5'h01;
            end
        end
    end

    // root of mean, division folded into the trial square
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            start_r <= 1'b0;
            busy_r  <= 1'b0;
            bit_r   <= 4'h0;
            root_r  <= 16'h0000;
            rms     <= 16'h0000;
            done    <= 1'b0;
        end else begin
            start_r <= step_tick;
            done    <= 1'b0;
            if (start_r) begin
                busy_r <= 1'b1;
                bit_r  <= 4'hF;
                root_r <= 16'h0000;
            end else if (busy_r) begin
                if (fits) begin
                    root_r <= trial;
                end
                bit_r <= bit_r - 4'h1;
                if (bit_r == 4'h0) begin
                    busy_r <= 1'b0;
                    rms    <= fits ? trial : root_r;
                    done   <= 1'b1;
                end
            end
        end
    end

endmodule : ltr_rms_phase

// >>> testbench/ltr_src_model.sv
`timescale 1ns/1ps
// Square wave source: its true RMS equals the amplitude at any tick phase
module ltr_src_model (
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire logic [14:0]   amp,
    output logic signed [15:0] sample_l1,
    output logic signed [15:0] sample_l2,
    output logic signed [15:0] sample_l3
);
    logic neg_r;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) neg_r <= 1'b0;
        else neg_r <= ~neg_r;
    end
    assign sample_l1 = neg_r ? -16'(amp) : 16'(amp);
    assign sample_l2 = neg_r ? -16'(amp >> 1) : 16'(amp >> 1);
    assign sample_l3 = neg_r ? -16'(amp >> 2) : 16'(amp >> 2);
endmodule : ltr_src_model

// >>> testbench/ltr_monitor.sv
`timescale 1ns/1ps
module ltr_monitor (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [1:0]  operation_mode_select,
    input wire logic [7:0]  alarm_threshold,
    input wire logic [7:0]  trip_threshold,
    input wire logic [7:0]  unlock_threshold,
    input wire logic        block_input,
    input wire logic        alarm_flag,
    input wire logic        general_trip_flag,
    input wire logic        reclose_lock_flag,
    input wire logic [15:0] calculated_temperature_value
);
    wire [15:0] tv = calculated_temperature_value;
    wire [1:0]  md = operation_mode_select;
    wire        trip = general_trip_flag;
    wire        lock = reclose_lock_flag;
    wire        act = alarm_flag | trip | lock;
    logic [7:0] quiet_r;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Level checks only once inputs and temperature have settled
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) quiet_r <= 8'h00;
        else if (block_input || md == 2'h0 || !$stable({tv, md,
                 alarm_threshold, trip_threshold, unlock_threshold}))
            quiet_r <= 8'h00;
        else if (quiet_r != 8'hFF) quiet_r <= quiet_r + 8'h01;
    end
    wire ok = quiet_r > 8'h07;
    chk_off_quiet: assert property ((md == 2'h0) [*4] |-> !act)
        else $error("flag active in off mode");
    chk_block_quiet: assert property (block_input [*5] |-> !act)
        else $error("flag active while blocked");
    chk_alarm_level: assert property (
        ok |-> alarm_flag == (tv > 16'(alarm_threshold)))
        else $error("alarm disagrees with temperature");
    chk_lock_set: assert property (
        ok && tv > 16'(trip_threshold) |-> lock) else $error("no lock");
    chk_lock_clear: assert property (
        ok && tv < 16'(unlock_threshold) && tv <= 16'(trip_threshold)
        |-> !lock) else $error("lock held");
    chk_locked_trip: assert property (
        ok && md == 2'h2 |-> trip == lock) else $error("trip not latched");
    chk_pulse_hold: assert property (
        $rose(trip) && md == 2'h1 && !block_input |=> trip [*8])
        else $error("trip pulse too short");
    chk_no_retrig: assert property (
        ok && md == 2'h1 && !trip |=> !trip) else $error("pulse retriggered");
    cov_trip: cover property ($rose(trip));
    cov_alarm: cover property ($rose(alarm_flag));
    cov_unlock: cover property ($fell(lock));
endmodule : ltr_monitor

bind ltr_thermal_replica ltr_monitor u_mon (.*);

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
    localparam int SC = 200;
    localparam int TP = 3;
    logic clk = 1'b0, resetn = 1'b0, sens = 1'b0, blk = 1'b0, hr = 1'b0;
    logic [1:0] mode = 2'h1;
    logic [7:0] alm = 8'h50, trp = 8'h64, rat = 8'h64, bas = 8'h19;
    logic [7:0] unl = 8'h3C, amb = 8'h19, mamb = 8'h00, st = 8'h00;
    logic [14:0] amp = 15'h0000;
    logic signed [15:0] sample_l1, sample_l2, sample_l3;
    logic fa, ft, fl;
    logic [15:0] tv, r1, r2, r3, e;
    logic [2:0] x;
    int failures = 0;
    int n_checks = 0;
    ltr_src_model src (.*);
    ltr_thermal_replica #(.STEP_CYCLES(SC), .TRIP_PULSE_STEPS(TP)) DUT (
        .clk, .resetn, .sample_l1, .sample_l2, .sample_l3,
        .measured_ambient(mamb), .operation_mode_select(mode),
        .alarm_threshold(alm), .trip_threshold(trp),
        .rated_temperature(rat), .base_temperature(bas),
        .unlock_threshold(unl), .fixed_ambient_temperature(amb),
        .startup_level(st), .rated_load_current(8'h64),
        .heating_time_constant(10'h00A), .ambient_sensor_select(sens),
        .block_input(blk), .heat_reset_input(hr), .alarm_flag(fa),
        .general_trip_flag(ft), .reclose_lock_flag(fl),
        .calculated_temperature_value(tv), .phase1_rms_current(r1),
        .phase2_rms_current(r2), .phase3_rms_current(r3));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic chk(input string nm, input logic [15:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task automatic cf(input string nm, input logic [2:0] v);
        chk(nm, 16'({fa, ft, fl}), 16'(v));
    endtask : cf
    function automatic logic [15:0] exp_t(input int s, r, b, a);
        return 16'(s * (r - b) / 100 + a);
    endfunction : exp_t
    task automatic test_done;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    initial forever #10 clk = ~clk;
    // Roughly three times the planned run
    initial begin
        #(40000 * 20);
        failures++;
        test_done();
    end
    initial begin
        cyc(12);
        resetn <= 1'b1;
        void'($urandom(73));
        amp <= 15'h05DC;
        cyc(21 * SC + 40);
        chk("rms1", r1, 16'h05DC);
        chk("rms2", r2, 16'h02EE);
        chk("rms3", r3, 16'h0177);
        for (int k = 0; k < 8; k++) begin
            mode <= 2'h0;
            hr <= 1'b1;
            amp <= 15'($urandom_range(1500));
            sens <= k > 1 ? 1'($urandom) : 1'b0;
            st <= k > 1 ? 8'($urandom_range(60)) : 8'h3C;
            rat <= k > 1 ? 8'($urandom_range(200, 60)) : 8'hC8;
            bas <= k > 1 ? 8'($urandom_range(40)) : 8'h00;
            amb <= k > 1 ? 8'($urandom_range(40)) : 8'h28;
            mamb <= 8'($urandom_range(60));
            alm <= k > 1 ? 8'($urandom_range(200, 60)) : 8'hA0 - 8'(k);
            trp <= k > 1 ? 8'($urandom_range(200, 60)) : 8'h9F + 8'(k);
            unl <= 8'($urandom_range(200, 20));
            cyc(12);
            e = exp_t(st, rat, bas, sens ? mamb : amb);
            chk("temp", tv, e);
            cf("off", 3'h0);
            x = {e > 16'(alm), e > 16'(trp), e > 16'(trp)};
            mode <= 2'h1 + 2'(k % 2);
            cyc(10);
            cf("on", x);
            blk <= 1'b1;
            cyc(6);
            blk <= 1'b0;
            cyc(8);
            cf("unblocked", x);
            cyc(TP * SC + 20);
            x[1] = x[1] & mode[1];
            cf("held", x);
            st <= 8'h00;
            unl <= 8'hC8;
            cyc(12);
            cf("cooled", 3'h0);
        end
        cyc(21 * SC + 40);
        chk("rms1r", r1, 16'(amp));
        chk("rms2r", r2, 16'(amp >> 1));
        chk("rms3r", r3, 16'(amp >> 2));
        test_done();
    end
endmodule : tb
